// ---- psp_pkg.sv ----
`default_nettype none
package psp_pkg;
	// ***************************************************************
	// register map (byte addresses, one word each)
	// ***************************************************************
	localparam logic [7:0] ADR_PORT_DATA = 8'hD8;
	localparam logic [7:0] ADR_PORT_CTL = 8'hE8;
	localparam logic [7:0] ADR_IRQ_STATUS = 8'hF0;
	localparam logic [7:0] ADR_IRQ_MASK = 8'hF4;

	// ***************************************************************
	// control/status fields
	// ***************************************************************
	localparam int CTL_IN_FULL = 0;
	localparam int CTL_OUT_FULL = 1;
	localparam int CTL_STROBE_MODE = 2;
	localparam int CTL_CLR_EDGE = 3;
	localparam int CTL_PIN_A_LSB = 4;
	localparam int CTL_PIN_B_LSB = 6;
	localparam int CTL_MODE_W = 6;
	localparam logic [7:0] CTL_RESET = 8'hFC;

	// pin function codes, shared by pin a and pin b
	localparam logic [1:0] PIN_LOW = 2'h0;
	localparam logic [1:0] PIN_HIGH = 2'h1;
	localparam logic [1:0] PIN_FLAG = 2'h2;
	localparam logic [1:0] PIN_INPUT = 2'h3;

	// ***************************************************************
	// interrupt status bits
	// ***************************************************************
	localparam int IRQ_W = 2;
	localparam int IRQ_IN_LOADED = 0;
	localparam int IRQ_OUT_TAKEN = 1;

	// ***************************************************************
	// synchroniser lane layout
	// ***************************************************************
	localparam int DATA_W = 8;
	localparam int SY_W = 12;
	localparam int SY_DATA_LSB = 0;
	localparam int SY_IN_STB = 8;
	localparam int SY_OUT_STB = 9;
	localparam int SY_PIN_A = 10;
	localparam int SY_PIN_B = 11;
	// strobes and flag pins idle high (pulled up)
	localparam logic [SY_W-1:0] SY_INIT = 12'h0F00;
endpackage
`default_nettype wire

// ---- psp_sync_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface psp_sync_if #(parameter int W = 12);
	logic [W-1:0] lvl;
	logic [W-1:0] rise;
	logic [W-1:0] fall;
	modport src (output lvl, output rise, output fall);
	modport dst (input lvl, input rise, input fall);
endinterface
`default_nettype wire

// ---- psp_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module psp_sync #(
	parameter int W = 12,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic core_clk, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic [W-1:0] raw, // pins from outside
	psp_sync_if.src sy // synchronised levels and edges
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
	} psp_sync_st_t;

	psp_sync_st_t st_r, st_nxt;

	// ***************************************************************
	// two-flop synchroniser, third stage only for edge detection
	// ***************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = raw;
		st_nxt.s2 = st_r.s1; // [R16]
		st_nxt.s3 = st_r.s2;
	end

	// reset to idle levels so no false edge appears at release
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= {INIT, INIT, INIT};
		end else begin
			st_r <= st_nxt;
		end
	end

	// s1 feeds only s2; edges are taken from later stages
	assign sy.lvl = st_r.s2;
	assign sy.rise = st_r.s2 & ~st_r.s3;
	assign sy.fall = ~st_r.s2 & st_r.s3;
endmodule
`default_nettype wire

// ---- psp_port.sv ----
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - control register is read/write except bits 0 and 1, which are read-only
// R2 - reset sets control bits 2 to 7 and clears bits 0 and 1
// R3 - strobe loading the input buffer sets the input-full flag in bit 0
// R4 - reading the data register clears the input-full flag
// R5 - writing the data register sets the output-full flag in bit 1
// R6 - strobe mode 0: load and flag on rising input strobe edge
// R7 - strobe mode 1: flag on falling edge, buffer transparent while strobe low
// R8 - output-full cleared on output strobe rise if bit 3 set, else fall
// R9 - bits 5:4 make pin a low, high, output-full, or select input
// R10 - select input low sends data register, high sends control register
// R11 - bits 7:6 make pin b low, high, input-full, or port gate input
// R12 - gate input high disables both strobes; low enables port input and output
// R13 - bit7=0, bits5:4=10 drive outputs always; output strobe only clears flag
// R14 - otherwise drive port only while output strobe is held low
// R15 - gate input high floats port drivers and blocks input latching
// R16 - strobe, flag and data pins are synchronised before their edges are used
module psp_port (
	input wire logic core_clk, // system clock, 25 MHz
	input wire logic resetn, // async reset, active low
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // transfer done
	input wire logic [psp_pkg::DATA_W-1:0] port_data_i, // port pins in
	output logic [psp_pkg::DATA_W-1:0] port_data_o, // port pins out
	output logic port_data_oe_n, // low while driving port
	input wire logic input_strobe_i, // input strobe pin
	input wire logic output_strobe_i, // output strobe pin
	input wire logic handshake_pin_a_i, // pin a in
	output logic handshake_pin_a_o, // pin a out
	output logic handshake_pin_a_oe_n, // low while driving pin a
	input wire logic handshake_pin_b_i, // pin b in
	output logic handshake_pin_b_o, // pin b out
	output logic handshake_pin_b_oe_n, // low while driving pin b
	output logic irq_o // level interrupt
);
	typedef struct packed {
		logic [psp_pkg::CTL_MODE_W-1:0] ctl;
		logic in_full;
		logic out_full;
		logic [psp_pkg::DATA_W-1:0] in_buf;
		logic [psp_pkg::DATA_W-1:0] out_buf;
		logic [psp_pkg::IRQ_W-1:0] irq_st;
		logic [psp_pkg::IRQ_W-1:0] irq_msk;
		logic irq;
		logic ack;
		logic [31:0] dat;
		logic [psp_pkg::DATA_W-1:0] pd_o;
		logic pd_oe_n;
		logic pa_o;
		logic pa_oe_n;
		logic pb_o;
		logic pb_oe_n;
	} psp_state_t;

	psp_state_t st_r, st_nxt;

	// ***************************************************************
	// pin synchronisation
	// ***************************************************************
	psp_sync_if #(.W(psp_pkg::SY_W)) sy ();

	// data rides the same pipeline as the strobes so a loaded byte
	// matches the edge that loads it
	psp_sync #(
		.W(psp_pkg::SY_W),
		.INIT(psp_pkg::SY_INIT)
	) u_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.raw({handshake_pin_b_i, handshake_pin_a_i, output_strobe_i,
			input_strobe_i, port_data_i}),
		.sy(sy)
	);

	// ***************************************************************
	// helpers
	// ***************************************************************
	// pin drive for the three output functions; input mode floats
	function automatic logic [1:0] pin_drive(input logic [1:0] mode, input logic flag);
		logic [1:0] r;
		r = 2'h0;
		case (mode)
			psp_pkg::PIN_LOW: r = 2'h0;
			psp_pkg::PIN_HIGH: r = 2'h2;
			psp_pkg::PIN_FLAG: r = {flag, 1'b0};
			psp_pkg::PIN_INPUT: r = 2'h1;
			default: r = 2'h1;
		endcase
		return r;
	endfunction

	// full control/status byte as seen by software and the select path
	function automatic logic [7:0] ctl_byte(input psp_state_t s);
		return {s.ctl, s.out_full, s.in_full};
	endfunction

	logic [psp_pkg::DATA_W-1:0] sy_data;
	logic in_stb, out_stb;
	logic [1:0] mode_a, mode_b;
	logic strobe_mode, clr_edge;
	logic gate_off, out_always, sel_ctl;
	logic ld_rise, ld_fall, ld_open, in_set, out_clr;
	logic req, commit, wr, lane0;
	logic wr_data, rd_data, wr_ctl, wr_st, wr_msk;
	logic [31:0] rd_val;

	// ***************************************************************
	// mode decode and strobe qualification
	// ***************************************************************
	always_comb begin
		sy_data = sy.lvl[psp_pkg::SY_DATA_LSB +: psp_pkg::DATA_W];
		in_stb = sy.lvl[psp_pkg::SY_IN_STB];
		out_stb = sy.lvl[psp_pkg::SY_OUT_STB];
		mode_a = st_r.ctl[psp_pkg::CTL_PIN_A_LSB-2 +: 2];
		mode_b = st_r.ctl[psp_pkg::CTL_PIN_B_LSB-2 +: 2];
		strobe_mode = st_r.ctl[psp_pkg::CTL_STROBE_MODE-2];
		clr_edge = st_r.ctl[psp_pkg::CTL_CLR_EDGE-2];
		gate_off = (mode_b == psp_pkg::PIN_INPUT) && sy.lvl[psp_pkg::SY_PIN_B]; // [R12] [R15]
		out_always = !mode_b[1] && (mode_a == psp_pkg::PIN_FLAG); // [R13]
		sel_ctl = (mode_a == psp_pkg::PIN_INPUT) && sy.lvl[psp_pkg::SY_PIN_A]; // [R10]
		ld_rise = !strobe_mode && sy.rise[psp_pkg::SY_IN_STB] && !gate_off; // [R6] [R16]
		ld_fall = strobe_mode && sy.fall[psp_pkg::SY_IN_STB] && !gate_off; // [R7]
		ld_open = strobe_mode && !in_stb && !gate_off; // [R7]
		in_set = ld_rise || ld_fall; // [R3]
		// edge choice per bit 3; gate blocks the strobe in every mode
		out_clr = !gate_off && (clr_edge ? sy.rise[psp_pkg::SY_OUT_STB]
			: sy.fall[psp_pkg::SY_OUT_STB]); // [R8]
	end

	// ***************************************************************
	// wishbone decode
	// ***************************************************************
	// side effects land on the ack edge, when the master takes the data
	always_comb begin
		req = wb_cyc_i && wb_stb_i;
		commit = req && st_r.ack;
		wr = commit && wb_we_i;
		lane0 = wb_sel_i[0];
		wr_data = wr && lane0 && (wb_adr_i == psp_pkg::ADR_PORT_DATA);
		wr_ctl = wr && lane0 && (wb_adr_i == psp_pkg::ADR_PORT_CTL);
		wr_st = wr && lane0 && (wb_adr_i == psp_pkg::ADR_IRQ_STATUS);
		wr_msk = wr && lane0 && (wb_adr_i == psp_pkg::ADR_IRQ_MASK);
		rd_data = commit && !wb_we_i && (wb_adr_i == psp_pkg::ADR_PORT_DATA);
		// unmapped addresses read zero and ignore writes
		case (wb_adr_i)
			psp_pkg::ADR_PORT_DATA: rd_val = {24'h00_0000, st_r.in_buf};
			psp_pkg::ADR_PORT_CTL: rd_val = {24'h00_0000, ctl_byte(st_r)};
			psp_pkg::ADR_IRQ_STATUS: rd_val = {30'h0000_0000, st_r.irq_st};
			psp_pkg::ADR_IRQ_MASK: rd_val = {30'h0000_0000, st_r.irq_msk};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// ***************************************************************
	// next state
	// ***************************************************************
	always_comb begin
		st_nxt = st_r;
		// one wait state: ack in the cycle after the request, then drop
		st_nxt.ack = req && !st_r.ack;
		if (req && !st_r.ack) begin
			st_nxt.dat = rd_val;
		end

		// flag bits 0 and 1 are never taken from write data
		if (wr_ctl) begin
			st_nxt.ctl = wb_dat_i[7:2]; // [R1]
		end
		if (wr_data) begin
			st_nxt.out_buf = wb_dat_i[psp_pkg::DATA_W-1:0];
		end

		// input buffer: edge load or transparent window
		if (ld_rise || ld_open) begin
			st_nxt.in_buf = sy_data; // [R6] [R7]
		end

		// read clears, strobe sets; set wins in the same cycle
		if (rd_data) begin
			st_nxt.in_full = 1'b0; // [R4]
		end
		if (in_set) begin
			st_nxt.in_full = 1'b1; // [R3]
		end

		// strobe clears, software write sets; set wins
		if (out_clr) begin
			st_nxt.out_full = 1'b0; // [R8]
		end
		if (wr_data) begin
			st_nxt.out_full = 1'b1; // [R5]
		end

		// interrupt status: write one to clear, new events win
		if (wr_st) begin
			st_nxt.irq_st = st_r.irq_st & ~wb_dat_i[psp_pkg::IRQ_W-1:0];
		end
		if (in_set) begin
			st_nxt.irq_st[psp_pkg::IRQ_IN_LOADED] = 1'b1;
		end
		if (out_clr && st_r.out_full) begin
			st_nxt.irq_st[psp_pkg::IRQ_OUT_TAKEN] = 1'b1;
		end
		if (wr_msk) begin
			st_nxt.irq_msk = wb_dat_i[psp_pkg::IRQ_W-1:0];
		end
		st_nxt.irq = |(st_r.irq_st & st_r.irq_msk);

		// port data source and drivers
		st_nxt.pd_o = sel_ctl ? ctl_byte(st_r) : st_r.out_buf; // [R10]
		if (out_always) begin
			st_nxt.pd_oe_n = 1'b0; // [R13]
		end else begin
			st_nxt.pd_oe_n = gate_off || out_stb; // [R14] [R15]
		end

		// handshake pins
		{st_nxt.pa_o, st_nxt.pa_oe_n} = pin_drive(mode_a, st_r.out_full); // [R9]
		{st_nxt.pb_o, st_nxt.pb_oe_n} = pin_drive(mode_b, st_r.in_full); // [R11]
	end

	// ***************************************************************
	// state register
	// ***************************************************************
	// reset leaves both pins as inputs and the port floating
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= '0;
			st_r.ctl <= psp_pkg::CTL_RESET[7:2]; // [R2]
			st_r.in_full <= psp_pkg::CTL_RESET[psp_pkg::CTL_IN_FULL]; // [R2]
			st_r.out_full <= psp_pkg::CTL_RESET[psp_pkg::CTL_OUT_FULL]; // [R2]
			st_r.pd_oe_n <= 1'b1;
			st_r.pa_oe_n <= 1'b1;
			st_r.pb_oe_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = st_r.dat;
	assign port_data_o = st_r.pd_o;
	assign port_data_oe_n = st_r.pd_oe_n;
	assign handshake_pin_a_o = st_r.pa_o;
	assign handshake_pin_a_oe_n = st_r.pa_oe_n;
	assign handshake_pin_b_o = st_r.pb_o;
	assign handshake_pin_b_oe_n = st_r.pb_oe_n;
	assign irq_o = st_r.irq;

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held for more than one cycle");

	ctl_write_keeps_a: assert property ( // [R1]
		(wr_ctl && !in_set && !rd_data) |=>
		(st_r.ctl == $past(wb_dat_i[7:2])) && (st_r.in_full == $past(st_r.in_full)))
		else $error("control write wrong or touched the input flag");

	in_full_set_a: assert property ( // [R3]
		in_set |=> st_r.in_full ##1 (st_r.in_full || $past(rd_data)))
		else $error("input flag not set by strobe load");

	in_full_clear_a: assert property ( // [R4]
		(rd_data && !in_set) |=> !st_r.in_full)
		else $error("input flag not cleared by data read");

	out_full_set_a: assert property (wr_data |=> st_r.out_full) // [R5]
		else $error("output flag not set by data write");

	rise_load_data_a: assert property ( // [R6]
		ld_rise |=> st_r.in_buf == $past(sy_data))
		else $error("input buffer missed rising edge load");

	out_clear_edge_a: assert property ( // [R8]
		(out_clr && !wr_data) |=> !st_r.out_full)
		else $error("output flag not cleared by strobe edge");

	gate_float_a: assert property ( // [R15]
		(gate_off && !out_always) |=> port_data_oe_n && $stable(st_r.in_full) || $past(rd_data))
		else $error("port driven or latched while gated off");

	always_drive_a: assert property (out_always [*2] |=> !port_data_oe_n) // [R13]
		else $error("output-always mode not driving port");

	pin_a_low_a: assert property ( // [R9]
		(mode_a == psp_pkg::PIN_LOW) |=> !handshake_pin_a_o && !handshake_pin_a_oe_n)
		else $error("pin a not driven low");

	pin_b_flag_a: assert property ( // [R11]
		(mode_b == psp_pkg::PIN_FLAG) |=> handshake_pin_b_o == $past(st_r.in_full))
		else $error("pin b not following input flag");

	select_source_a: assert property ( // [R10]
		sel_ctl |=> port_data_o == $past(ctl_byte(st_r)))
		else $error("select input did not pick control byte");

	transparent_load_a: assert property ( // [R7]
		ld_open |=> st_r.in_buf == $past(sy_data))
		else $error("input buffer not following pins while strobe low");

	strobe_drive_a: assert property ( // [R14]
		(!out_always && !gate_off && !out_stb) |=> !port_data_oe_n)
		else $error("port not driven while output strobe low");

	gate_hold_buf_a: assert property (gate_off |=> $stable(st_r.in_buf)) // [R12] [R15]
		else $error("input buffer changed while gated off");

	pin_a_high_a: assert property ( // [R9]
		(mode_a == psp_pkg::PIN_HIGH) |=> handshake_pin_a_o && !handshake_pin_a_oe_n)
		else $error("pin a not driven high");

	pin_b_input_a: assert property ( // [R11]
		(mode_b == psp_pkg::PIN_INPUT) |=> handshake_pin_b_oe_n)
		else $error("pin b driven while an input");

	irq_clear_a: assert property (
		(wr_st && !in_set && !out_clr) |=>
		(st_r.irq_st & $past(wb_dat_i[psp_pkg::IRQ_W-1:0])) == '0)
		else $error("status bit not cleared by write of one");

	irq_level_a: assert property (
		(|(st_r.irq_st & st_r.irq_msk)) |=> irq_o)
		else $error("interrupt not raised for unmasked status");
endmodule
`default_nettype wire

// ---- psp_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
// *****
// far-side peer on the strobed port
// *****
module psp_peer (
	input wire logic core_clk, // system clock
	output logic [7:0] pd, // byte offered to the port
	output logic pd_en, // high while peer drives the port
	output logic istb, // input strobe, idle high
	output logic ostb, // output strobe, idle high
	output logic pa, // select level for pin a
	output logic pa_en, // high while peer drives pin a
	output logic pb, // gate level for pin b
	output logic pb_en // high while peer drives pin b
);
	// idle: strobes high, all else released to the pull-ups
	initial begin
		{pd, pd_en, pa, pa_en, pb, pb_en} = '0;
		{istb, ostb} = 2'h3;
	end
	// one bus phase; 5 cycles keeps every strobe wider than the 3-cycle minimum
	task automatic bus(input logic [7:0] d, input logic de, input logic i, input logic o);
		@(posedge core_clk);
		pd <= d;
		pd_en <= de;
		istb <= i;
		ostb <= o; // low only while the byte is wanted
		repeat (5) @(posedge core_clk);
	endtask
	// levels for the two flag pins when they are inputs
	task automatic flags(input logic ae, input logic a, input logic be, input logic b);
		@(posedge core_clk);
		pa_en <= ae;
		pa <= a; // low picks data, high picks control
		pb_en <= be;
		pb <= b; // high shuts the port
		repeat (5) @(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// ---- tb_strobed_parallel_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_strobed_parallel_port;
	logic core_clk, resetn, cyc, stb, we, ack, irq;
	logic [7:0] adr, pd, pins, pdo, q, d, d2, ctl;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic pdoe_n, pd_en, istb, ostb, pa, pa_en, pb, pb_en;
	logic pa_o, pa_oe_n, pb_o, pb_oe_n, pa_w, pb_w;
	logic [1:0] mm;
	int bad_count, n_tests;

	// pins resolve with pull-ups; the device wins while its enable is low
	assign pins = !pdoe_n ? pdo : pd_en ? pd : 8'hFF;
	assign pa_w = !pa_oe_n ? pa_o : pa_en ? pa : 1'b1;
	assign pb_w = !pb_oe_n ? pb_o : pb_en ? pb : 1'b1;

	psp_port DUT (.core_clk(core_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .port_data_i(pins), .port_data_o(pdo), .port_data_oe_n(pdoe_n),
		.input_strobe_i(istb), .output_strobe_i(ostb), .handshake_pin_a_i(pa_w),
		.handshake_pin_a_o(pa_o), .handshake_pin_a_oe_n(pa_oe_n), .handshake_pin_b_i(pb_w),
		.handshake_pin_b_o(pb_o), .handshake_pin_b_oe_n(pb_oe_n), .irq_o(irq));
	psp_peer peer (.core_clk(core_clk), .pd(pd), .pd_en(pd_en), .istb(istb), .ostb(ostb),
		.pa(pa), .pa_en(pa_en), .pb(pb), .pb_en(pb_en));

	// 25 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// *****
	// expectations and bus tasks
	// *****
	function automatic logic [7:0] csr_exp(input logic [7:0] c, input logic i, input logic o);
		return {c[7:2], o, i};
	endfunction
	function automatic logic [7:0] pin_exp(input logic [1:0] m, input logic f);
		return {6'h00, m == 2'h3, (m == 2'h1) | ((m == 2'h2) & f)};
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= {24'h00_0000, v};
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			bad_count++;
			complete_run();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		wb(1'b1, a, v, 4'h1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		wb(1'b0, a, 8'h00, 4'h1);
		chk(q, exp, what);
	endtask

	// hang guard
	initial begin
		repeat (5000) @(posedge core_clk);
		bad_count++;
		complete_run();
	end

	// *****
	// main sequence
	// *****
	initial begin
		{cyc, stb, we, adr, sel, wdat} = '0;
		resetn = 1'b0;
		bad_count = 0;
		n_tests = 0;
		void'($urandom(23));
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		rd(psp_pkg::ADR_PORT_CTL, 8'hFC, "ctl reset");
		rd(psp_pkg::ADR_IRQ_MASK, 8'h00, "mask reset");
		rd(8'h10, 8'h00, "unmapped");
		// every pin code on both pins; random low bits also hit the read-only flags
		for (int m = 0; m < 4; m++) begin
			mm = 2'(m);
			ctl = {mm, mm, 4'($urandom)};
			wr(psp_pkg::ADR_PORT_CTL, ctl);
			rd(psp_pkg::ADR_PORT_CTL, csr_exp(ctl, 1'b0, 1'b0), "ctl rw");
			chk({6'h00, pa_oe_n, pa_o & (mm != 2'h3)}, pin_exp(mm, 1'b0), "pin a");
			chk({6'h00, pb_oe_n, pb_o & (mm != 2'h3)}, pin_exp(mm, 1'b0), "pin b");
		end
		wb(1'b1, psp_pkg::ADR_PORT_CTL, 8'h00, 4'h2);
		rd(psp_pkg::ADR_PORT_CTL, csr_exp(ctl, 1'b0, 1'b0), "lane off write");
		// input, rising-edge load, interrupt unmasked
		d = 8'($urandom);
		d2 = ~d;
		wr(psp_pkg::ADR_IRQ_MASK, 8'h01);
		wr(psp_pkg::ADR_PORT_CTL, 8'hA0);
		peer.bus(d, 1'b1, 1'b0, 1'b1);
		rd(psp_pkg::ADR_PORT_CTL, csr_exp(8'hA0, 1'b0, 1'b0), "no flag on fall");
		peer.bus(d2, 1'b1, 1'b0, 1'b1);
		peer.bus(d2, 1'b1, 1'b1, 1'b1);
		rd(psp_pkg::ADR_PORT_CTL, csr_exp(8'hA0, 1'b1, 1'b0), "in full");
		chk({7'h00, pb_o}, 8'h01, "pin b shows full");
		chk({7'h00, irq}, 8'h01, "irq raised");
		rd(psp_pkg::ADR_PORT_DATA, d2, "byte at rise");
		rd(psp_pkg::ADR_PORT_CTL, csr_exp(8'hA0, 1'b0, 1'b0), "read clears");
		wr(psp_pkg::ADR_IRQ_STATUS, 8'h01);
		repeat (2) @(posedge core_clk);
		chk({7'h00, irq}, 8'h00, "irq cleared");
		// input, transparent mode, interrupt masked
		wr(psp_pkg::ADR_IRQ_MASK, 8'h00);
		wr(psp_pkg::ADR_PORT_CTL, 8'hA4);
		peer.bus(d, 1'b1, 1'b0, 1'b1);
		rd(psp_pkg::ADR_PORT_CTL, csr_exp(8'hA4, 1'b1, 1'b0), "flag on fall");
		peer.bus(d2, 1'b1, 1'b0, 1'b1);
		peer.bus(d2, 1'b1, 1'b1, 1'b1);
		peer.bus(d, 1'b1, 1'b1, 1'b1);
		peer.bus(8'h00, 1'b0, 1'b1, 1'b1);
		rd(psp_pkg::ADR_PORT_DATA, d2, "held while high");
		chk({7'h00, irq}, 8'h00, "irq masked");
		rd(psp_pkg::ADR_IRQ_STATUS, 8'h01, "status while masked");
		// output, flag cleared on falling strobe
		wr(psp_pkg::ADR_PORT_DATA, d);
		rd(psp_pkg::ADR_PORT_CTL, csr_exp(8'hA4, 1'b0, 1'b1), "out full");
		chk({6'h00, pa_o, pdoe_n}, 8'h03, "pin a full, port idle");
		peer.bus(8'h00, 1'b0, 1'b1, 1'b0);
		chk({pdo[6:0], pdoe_n}, {d[6:0], 1'b0}, "driven byte");
		rd(psp_pkg::ADR_PORT_CTL, csr_exp(8'hA4, 1'b0, 1'b0), "clear on fall");
		rd(psp_pkg::ADR_IRQ_STATUS, 8'h03, "taken event");
		peer.bus(8'h00, 1'b0, 1'b1, 1'b1);
		chk({7'h00, pdoe_n}, 8'h01, "released");
		// output, flag cleared on rising strobe
		wr(psp_pkg::ADR_PORT_CTL, 8'hAC);
		wr(psp_pkg::ADR_PORT_DATA, d2);
		peer.bus(8'h00, 1'b0, 1'b1, 1'b0);
		rd(psp_pkg::ADR_PORT_CTL, csr_exp(8'hAC, 1'b0, 1'b1), "kept while low");
		peer.bus(8'h00, 1'b0, 1'b1, 1'b1);
		rd(psp_pkg::ADR_PORT_CTL, csr_exp(8'hAC, 1'b0, 1'b0), "clear on rise");
		// pin a as source select
		wr(psp_pkg::ADR_PORT_CTL, 8'h38);
		wr(psp_pkg::ADR_PORT_DATA, d);
		peer.flags(1'b1, 1'b1, 1'b0, 1'b0);
		peer.bus(8'h00, 1'b0, 1'b1, 1'b0);
		chk(pdo, csr_exp(8'h38, 1'b0, 1'b1), "control on port");
		peer.flags(1'b1, 1'b0, 1'b0, 1'b0);
		chk(pdo, d, "data on port");
		peer.bus(8'h00, 1'b0, 1'b1, 1'b1);
		// pin b as port gate: shut, then open
		wr(psp_pkg::ADR_PORT_CTL, 8'hC8);
		// refill so the gated strobes have a full flag they must not clear
		wr(psp_pkg::ADR_PORT_DATA, d);
		peer.flags(1'b0, 1'b0, 1'b1, 1'b1);
		peer.bus(d, 1'b1, 1'b0, 1'b0);
		chk({7'h00, pdoe_n}, 8'h01, "gated float");
		peer.bus(d, 1'b1, 1'b1, 1'b1);
		rd(psp_pkg::ADR_PORT_CTL, csr_exp(8'hC8, 1'b0, 1'b1), "gated strobes");
		peer.flags(1'b0, 1'b0, 1'b1, 1'b0);
		peer.bus(d2, 1'b1, 1'b0, 1'b1);
		peer.bus(d2, 1'b1, 1'b1, 1'b1);
		peer.bus(8'h00, 1'b0, 1'b1, 1'b1);
		rd(psp_pkg::ADR_PORT_DATA, d2, "open gate loads");
		// output-always mode drives with no strobe
		wr(psp_pkg::ADR_PORT_CTL, 8'h20);
		repeat (4) @(posedge core_clk);
		chk({pdo[6:0], pdoe_n}, {d[6:0], 1'b0}, "always driven");
		complete_run();
	end
endmodule
`default_nettype wire
